// *** rtl/ddt_timer.sv ***
// Dual 8-bit down counter timer with 16-bit cascade, event counting and wave output.
// Assumes a classic Wishbone master on clk_i and an asynchronous event pin.
`timescale 1ns/1ns
`default_nettype none
module ddt_timer
  import ddt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        shared_event_pin_i,
  output logic             event_port_o,
  output logic             timer_wave_out_o,
  output logic             fast_oscillator_on_o,
  output logic             irq_pending_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [6:0]  ctrl;
  logic [15:0] reload;
  logic [1:0]  mask;
  logic [1:0]  flag;
  logic [1:0]  run_act;
  logic [7:0]  cnt0;
  logic [7:0]  cnt1;
  logic [3:0]  hi_latch0;
  logic [3:0]  hi_latch1;
  logic        pin_s1;
  logic        pin_s2;
  logic        pin_s3;
  logic [7:0]  div;
  logic        wave;
  logic        ack_d;

  wire access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr       = access & wb_we_i & wb_sel_i[0];
  wire rd       = access & ~wb_we_i;
  wire wr_ctrl  = wr & (wb_adr_i == DDT_CTRL_OFS);
  wire wr_rld   = access & wb_we_i & (wb_adr_i == DDT_RELOAD_OFS);
  wire wr_flag  = wr & (wb_adr_i == DDT_FLAG_OFS);
  wire wr_mask  = wr & (wb_adr_i == DDT_MASK_OFS);
  wire rd_c0lo  = rd & (wb_adr_i == DDT_C0LO_OFS);
  wire rd_c1lo  = rd & (wb_adr_i == DDT_C1LO_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Input clock: prescaled tick, or falling edge on the event pin
  wire        cascade  = ctrl[DDT_CASC_BIT];
  wire [7:0]  div_top  = ctrl[DDT_FAST_BIT] ? DDT_FAST_DIV : DDT_SLOW_DIV;
  wire        pre_tick = (div == div_top);
  wire        pin_fall = pin_s3 & ~pin_s2;
  wire        in_fall  = ctrl[DDT_EVT_BIT] ? pin_fall : pre_tick;
  wire        fire0    = in_fall & run_act[0];
  wire        uf0      = fire0 & (cnt0 == 8'h00);
  wire        tick1    = cascade ? uf0 : in_fall;
  wire        run1_src = cascade ? run_act[0] : run_act[1];
  wire        fire1    = tick1 & run1_src;
  wire        uf1      = fire1 & (cnt1 == 8'h00);
  wire [1:0]  ev       = cascade ? {uf1, 1'b0} : {uf1, uf0};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      div    <= 8'h00;
    end else begin
      pin_s1 <= shared_event_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      div    <= pre_tick ? 8'h00 : div + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run state follows the written bit only on an input clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_act <= 2'b00;
    end else if (in_fall) begin
      run_act <= {ctrl[DDT_RUN1_BIT], ctrl[DDT_RUN0_BIT]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt0 <= DDT_RELOAD_RST[7:0];
      cnt1 <= DDT_RELOAD_RST[15:8];
    end else begin
      if (fire0) begin
        cnt0 <= (cnt0 == 8'h00) ? reload[7:0] : cnt0 - 8'h01;
      end
      if (fire1) begin
        cnt1 <= (cnt1 == 8'h00) ? reload[15:8] : cnt1 - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= DDT_CTRL_RST;
      reload <= DDT_RELOAD_RST;
      mask   <= DDT_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wb_dat_i[6:0];
      end
      if (wr_rld) begin
        if (wb_sel_i[0]) reload[7:0]  <= wb_dat_i[7:0];
        if (wb_sel_i[1]) reload[15:8] <= wb_dat_i[15:8];
      end
      if (wr_mask) begin
        mask <= wb_dat_i[1:0];
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag <= 2'b00;
    end else begin
      flag <= (flag & ~(wr_flag ? wb_dat_i[1:0] : 2'b00)) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_latch0 <= 4'h0;
      hi_latch1 <= 4'h0;
    end else begin
      if (rd_c0lo) hi_latch0 <= cnt0[7:4];
      if (rd_c1lo) hi_latch1 <= cnt1[7:4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; run bits read one while the counter still runs
  wire [1:0]  run_rd  = {ctrl[DDT_RUN1_BIT], ctrl[DDT_RUN0_BIT]} | run_act;
  wire [31:0] ctrl_rd = {23'h000000, pin_s2, 1'b0, ctrl[6:2], run_rd};
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      DDT_CTRL_OFS:   rd_mux = ctrl_rd;
      DDT_RELOAD_OFS: rd_mux = {16'h0000, reload};
      DDT_C0LO_OFS:   rd_mux = {28'h0000000, cnt0[3:0]};
      DDT_C0HI_OFS:   rd_mux = {28'h0000000, hi_latch0};
      DDT_C1LO_OFS:   rd_mux = {28'h0000000, cnt1[3:0]};
      DDT_C1HI_OFS:   rd_mux = {28'h0000000, hi_latch1};
      DDT_FLAG_OFS:   rd_mux = {30'h00000000, flag};
      DDT_MASK_OFS:   rd_mux = {30'h00000000, mask};
      default:        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= rd ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: wave toggles on channel 1 underflow in both modes, gated by enable
  wire wave_src = cascade ? uf1 : uf1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave                 <= 1'b0;
      timer_wave_out_o     <= 1'b0;
      event_port_o         <= 1'b0;
      fast_oscillator_on_o <= 1'b0;
      irq_pending_o        <= 1'b0;
      ack_d                <= 1'b0;
    end else begin
      if (wave_src) wave <= ~wave;
      timer_wave_out_o     <= wave & ctrl[DDT_WAVE_BIT];
      event_port_o         <= pin_s2;
      fast_oscillator_on_o <= ctrl[DDT_OSCON_BIT];
      irq_pending_o        <= |(flag & mask);
      ack_d                <= wb_ack_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_clear_req0;
    run_act[0] && !ctrl[DDT_RUN0_BIT];
  endsequence

  chk_stop_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_clear_req0 and in_fall) |=> !run_act[0])
    else $error("channel zero did not stop at input edge");
  chk_run_held: assert property (@(posedge clk_i) disable iff (rst_i)
    (!in_fall) |=> $stable(run_act))
    else $error("run state changed without input edge");
  chk_run_reads_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && (wb_adr_i == DDT_CTRL_OFS) && run_act[0]) |=> wb_dat_o[DDT_RUN0_BIT])
    else $error("run bit read zero while running");
  chk_event_start: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl[DDT_EVT_BIT] && !pin_fall && $rose(ctrl[DDT_RUN0_BIT])) |=> $stable(run_act[0]))
    else $error("event mode started without pin edge");
  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[0] |=> flag[0])
    else $error("factor flag not set on underflow");
  chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag[1] && !(wr_flag && wb_dat_i[1])) |=> flag[1])
    else $error("factor flag cleared without write");
  chk_irq_repeat: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag[0] && mask[0]) [*2] |-> irq_pending_o)
    else $error("pending flag gives no interrupt");
  chk_latch_high: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_c0lo |=> (hi_latch0 == $past(cnt0[7:4])))
    else $error("high nibble not latched on low read");
  chk_osc_reset: assert property (@(posedge clk_i)
    $fell(rst_i) |-> !fast_oscillator_on_o)
    else $error("fast oscillator on after reset");
  chk_cascade_uf: assert property (@(posedge clk_i) disable iff (rst_i)
    (cascade && !uf0) |=> $stable(cnt1))
    else $error("upper channel moved without lower underflow");
  chk_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule : ddt_timer
`default_nettype wire

// *** common/ddt_pkg.sv ***
// Package for the dual down counter timer: register map, field positions, reset values.
// Assumes a 32-bit classic Wishbone slave decoding all 8 bits of the byte address.
package ddt_pkg;
  localparam logic [7:0] DDT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DDT_RELOAD_OFS = 8'h04;
  localparam logic [7:0] DDT_C0LO_OFS   = 8'h08;
  localparam logic [7:0] DDT_C0HI_OFS   = 8'h0c;
  localparam logic [7:0] DDT_C1LO_OFS   = 8'h10;
  localparam logic [7:0] DDT_C1HI_OFS   = 8'h14;
  localparam logic [7:0] DDT_FLAG_OFS   = 8'h18;
  localparam logic [7:0] DDT_MASK_OFS   = 8'h1c;
  localparam int DDT_RUN0_BIT  = 0;
  localparam int DDT_RUN1_BIT  = 1;
  localparam int DDT_CASC_BIT  = 2;
  localparam int DDT_EVT_BIT   = 3;
  localparam int DDT_FAST_BIT  = 4;
  localparam int DDT_OSCON_BIT = 5;
  localparam int DDT_WAVE_BIT  = 6;
  localparam int DDT_PIN_BIT   = 8;
  localparam logic [6:0]  DDT_CTRL_RST   = 7'h00;
  localparam logic [15:0] DDT_RELOAD_RST = 16'hffff;
  localparam logic [1:0]  DDT_MASK_RST   = 2'h0;
  // Input clock dividers: slow and fast prescaled ticks from clk_i
  localparam logic [7:0] DDT_SLOW_DIV = 8'hff;
  localparam logic [7:0] DDT_FAST_DIV = 8'h03;
endpackage : ddt_pkg

// *** testbench/ddt_host_model.sv ***
// Host model: classic Wishbone master standing in for the CPU core.
// Assumes a slave on clk_i that acks every request it takes.
`timescale 1ns/1ns
`default_nettype none
module ddt_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // One single cycle; held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    dat_o <= ~d;
  endtask : xfer
endmodule : ddt_host_model
`default_nettype wire

// *** testbench/ddt_timer_tb_top.sv ***
// Testbench for ddt_timer: registers, event counting, flags and wave gate.
// Assumes ddt_host_model as bus master and a 25 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module ddt_timer_tb_top;
  import ddt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        pin   = 1'b1;
  logic        cyc, stb, we, ack, evt_port, wave, osc, irq, seen;
  logic [7:0]  adr, v, c, r;
  logic [31:0] wdat, rdat, q;
  int          err_total = 0;
  int          n_checks  = 0;
  int          seed      = 40;
  int          i;
  always #20 clk_i = ~clk_i;
  ddt_timer ddt_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .shared_event_pin_i(pin), .event_port_o(evt_port),
    .timer_wave_out_o(wave), .fast_oscillator_on_o(osc), .irq_pending_o(irq));
  ddt_host_model ddt_host_model_inst (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat));
  ////////////////////////////////////////////////////////////////////////////
  // Control read-back: pin idles high, run0 reads one while still active
  function automatic logic [31:0] ctrl_rd(input logic [6:0] k, input logic act);
    return {23'h0, 1'b1, 1'b0, k[6:1], k[0] | act};
  endfunction : ctrl_rd
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : check
  task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ddt_host_model_inst.xfer(1'b0, a, 32'h0, d);
    check(d, e);
  endtask : check_reg
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ddt_host_model_inst.xfer(1'b1, a, d, x);
  endtask : wr
  task automatic rd_cnt(output logic [7:0] k);
    logic [31:0] lo;
    logic [31:0] hi;
    ddt_host_model_inst.xfer(1'b0, DDT_C0LO_OFS, 32'h0, lo);
    ddt_host_model_inst.xfer(1'b0, DDT_C0HI_OFS, 32'h0, hi);
    k = {hi[3:0], lo[3:0]};
  endtask : rd_cnt
  task automatic pulse;
    pin <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(32'(evt_port), 32'h0);
    pin <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask : pulse
  task automatic watch(output logic s);
    s = 1'b0;
    repeat (1500) begin
      @(posedge clk_i);
      s = s | wave;
    end
  endtask : watch
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    err_total++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check(32'(osc), 32'h0);
    // Let the pin synchroniser reach the idle level before the first read
    repeat (2) @(posedge clk_i);
    check_reg(DDT_CTRL_OFS, ctrl_rd(DDT_CTRL_RST, 1'b0));
    check_reg(DDT_RELOAD_OFS, {16'h0, DDT_RELOAD_RST});
    check_reg(DDT_MASK_OFS, {30'h0, DDT_MASK_RST});
    wr(8'h40, 32'hffff_ffff);
    check_reg(8'h40, 32'h0);
    $display("test reset done");
    wr(DDT_CTRL_OFS, 32'h09);
    pulse();
    rd_cnt(v);
    rd_cnt(c);
    check(32'(c), 32'(v));
    pulse();
    rd_cnt(c);
    check(32'(c), 32'(v - 8'h1));
    wr(DDT_CTRL_OFS, 32'h08);
    check_reg(DDT_CTRL_OFS, ctrl_rd(7'h08, 1'b1));
    rd_cnt(v);
    check(32'(v), 32'(c));
    pulse();
    rd_cnt(v);
    check(32'(v), 32'(c - 8'h1));
    check_reg(DDT_CTRL_OFS, ctrl_rd(7'h08, 1'b0));
    pulse();
    rd_cnt(c);
    check(32'(c), 32'(v));
    $display("test event run stop done");
    wr(DDT_CTRL_OFS, 32'h20);
    repeat (100) @(posedge clk_i);
    check(32'(osc), 32'h1);
    r = 8'($random(seed)) & 8'h0f;
    wr(DDT_RELOAD_OFS, {16'h0, 8'h03, r});
    wr(DDT_CTRL_OFS, 32'h31);
    q = 32'h0;
    for (i = 0; i < 1000 && q[0] !== 1'b1; i++)
      ddt_host_model_inst.xfer(1'b0, DDT_FLAG_OFS, 32'h0, q);
    check(q & 32'h1, 32'h1);
    check(32'(irq), 32'h0);
    wr(DDT_MASK_OFS, 32'h1);
    repeat (3) @(posedge clk_i);
    check(32'(irq), 32'h1);
    wr(DDT_CTRL_OFS, 32'h20);
    repeat (20) @(posedge clk_i);
    check(32'(irq), 32'h1);
    wr(DDT_FLAG_OFS, 32'h3);
    check_reg(DDT_FLAG_OFS, 32'h0);
    check(32'(irq), 32'h0);
    $display("test flag done");
    wr(DDT_CTRL_OFS, 32'h32);
    watch(seen);
    check(32'(seen), 32'h0);
    wr(DDT_CTRL_OFS, 32'h72);
    watch(seen);
    check(32'(seen), 32'h1);
    $display("test wave done");
    // Cascade: only the upper flag sets; nibbles read in order
    wr(DDT_CTRL_OFS, 32'h35);
    wr(DDT_FLAG_OFS, 32'h3);
    q = 32'h0;
    for (i = 0; i < 1000 && q[1] !== 1'b1; i++)
      ddt_host_model_inst.xfer(1'b0, DDT_FLAG_OFS, 32'h0, q);
    check(q, 32'h2);
    ddt_host_model_inst.xfer(1'b0, DDT_C0LO_OFS, 32'h0, q);
    ddt_host_model_inst.xfer(1'b0, DDT_C0HI_OFS, 32'h0, q);
    ddt_host_model_inst.xfer(1'b0, DDT_C1LO_OFS, 32'h0, q);
    check(32'(q[3:0] <= 4'h3), 32'h1);
    ddt_host_model_inst.xfer(1'b0, DDT_C1HI_OFS, 32'h0, q);
    check(q, 32'h0);
    wr(DDT_CTRL_OFS, 32'h20);
    $display("test cascade done");
    conclude();
  end
endmodule : ddt_timer_tb_top
`default_nettype wire
